// *** sim/icw_link_model.sv ***
// icw_link_model: mode handler levels and successful-cycle pulses of the line side
// assumes the bench calls its tasks; it drives on the falling clock edge
`timescale 1ns/1ns
`default_nettype none
module icw_link_model (
  input wire logic clk_i,
  output logic estcom_o,
  output logic operate_o,
  output logic cycle_done_o
);
  initial begin
    estcom_o = 1'b0;
    operate_o = 1'b0;
    cycle_done_o = 1'b0;
  end
  task automatic set_mode(input logic e, input logic o);
    @(negedge clk_i);
    estcom_o = e;
    operate_o = o;
  endtask : set_mode
  // pulses spaced one idle cycle apart so none merge
  task automatic cycles(input int n);
    repeat (n) begin
      @(negedge clk_i);
      cycle_done_o = 1'b1;
      @(negedge clk_i);
      cycle_done_o = 1'b0;
    end
  endtask : cycles
endmodule : icw_link_model
`default_nettype wire

// *** sim/icw_regs_tb.sv ***
// icw_regs_tb: self-checking bench of the register block
// assumes the link model in icw_link_model.sv; inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module icw_regs_tb;
  import icw_pkg::*;
  logic clk_i, arst_n_i, wr, rd, crc, pld, pwr, fclr;
  logic [7:0] addr, wd, pa, rdat, v;
  logic [5:0] fl;
  logic [1:0] dsel, rsel, rate, mode;
  logic [3:0] dbits;
  logic ack, acc, crca, hold, mrst, tf, tout, irq, est, op, cd;
  logic [7:0] pg [4] = '{8'h04, 8'h09, 8'h0a, 8'h0b};
  int err_count = 0, checked = 0;
  always #2 clk_i = ~clk_i;
  icw_regs icw_regs_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_ack_o(ack), .isdu_flag_register_i(fl), .spi_crc_pin_i(crc),
    .link_estcom_i(est), .link_operate_i(op), .cycle_done_i(cd), .process_input_data_load_i(pld),
    .page_wr_req_i(pwr), .page_wr_addr_i(pa), .timeout_flag_clear_i(fclr), .page_wr_accept_o(acc),
    .answer_delay_sel_o(dsel), .answer_delay_bits_o(dbits), .link_rate_sel_o(rsel), .link_rate_o(rate),
    .spi_crc_active_o(crca), .sio_hold_o(hold), .mode_handler_reset_o(mrst), .link_mode_o(mode),
    .cycle_timeout_flag_o(tf), .cycle_timeout_output_o(tout), .irq_o(irq));
  icw_link_model icw_link_model_i (.clk_i(clk_i), .estcom_o(est), .operate_o(op), .cycle_done_o(cd));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task end_of_test;
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr = 1;
    addr = a;
    wd = d;
    @(negedge clk_i);
    wr = 0;
  endtask : wreg
  task rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd = 1;
    addr = a;
    @(negedge clk_i);
    rd = 0;
    d = rdat;
    chk("ack", ack, 1);
  endtask : rreg
  task clr_flag;
    @(negedge clk_i);
    fclr = 1;
    @(negedge clk_i);
    fclr = 0;
    chk("flag_clr", tf, 0);
  endtask : clr_flag
  task t_reset;
    rreg(ICW_ADDR_ISDU_MASK, v);
    chk("mask_rst", v, 0);
    rreg(ICW_ADDR_WDG_LIMIT, v);
    chk("wdg_rst", v, 0);
    chk("dly_rst", dbits, 2);
    wreg(ICW_ADDR_ISDU_MASK, 8'hff);
    rreg(ICW_ADDR_ISDU_MASK, v);
    chk("mask_rb", v, 8'h3f);
    rreg(8'h20, v);
    chk("unmapped", v, 0);
    wreg(ICW_ADDR_CLR_CFG, 8'hfe);
    rreg(ICW_ADDR_CLR_CFG, v);
    chk("clr_cfg_rb", v, 0);
  endtask : t_reset
  task t_irq;
    for (int i = 0; i < 6; i++) begin
      wreg(ICW_ADDR_ISDU_MASK, 8'h3f ^ (8'h01 << i));
      fl = 6'h01 << i;
      #1 chk("irq_masked", irq, 0);
      wreg(ICW_ADDR_ISDU_MASK, 8'h01 << i);
      chk("irq_on", irq, 1);
      fl = 0;
      #1 chk("irq_rel", irq, 0);
    end
  endtask : t_irq
  task t_cfg;
    for (int i = 0; i < 4; i++) begin
      wreg(ICW_ADDR_LINK_CFG, 8'(i * 68));
      chk("delay", dbits, 8'(2 * i + 2));
      chk("delay_sel", dsel, 8'(i));
      chk("rate_sel", rsel, 8'(i));
      chk("rate", rate, (i == 3) ? 8'h00 : 8'(i));
    end
    wreg(ICW_ADDR_LINK_CFG, 8'h10);
    chk("crc_bit", crca, 1);
    wreg(ICW_ADDR_LINK_CFG, 8'h00);
    chk("crc_off", crca, 0);
    crc = 1;
    repeat (3) @(negedge clk_i);
    chk("crc_pin", crca, 1);
    crc = 0;
    repeat (3) @(negedge clk_i);
    chk("crc_pin_low", crca, 0);
    icw_link_model_i.set_mode(0, 1);
    @(negedge clk_i);
    chk("sio_undone", mode, 0);
    wreg(ICW_ADDR_LINK_CFG, 8'h20);
    @(negedge clk_i);
    chk("operate", {hold, mrst, mode}, 8'h02);
    wreg(ICW_ADDR_LINK_CFG, 8'h21);
    @(negedge clk_i);
    chk("force", {hold, mrst, mode}, 8'h0c);
  endtask : t_cfg
  task t_page;
    pwr = 1;
    for (int i = 0; i < 4; i++) begin
      wreg(ICW_ADDR_LINK_CFG, 8'h02);
      pa = pg[i];
      #1 chk("page_block", acc, 0);
      wreg(ICW_ADDR_LINK_CFG, 8'h00);
      chk("page_ok", acc, 1);
    end
    wreg(ICW_ADDR_LINK_CFG, 8'h02);
    pa = 8'h0c;
    #1 chk("page_other", acc, 1);
    pwr = 0;
    #1 chk("page_idle", acc, 0);
  endtask : t_page
  task t_wdg;
    wreg(ICW_ADDR_LINK_MASK, 8'h80);
    rreg(ICW_ADDR_LINK_MASK, v);
    chk("lmask_rb", v, 8'h80);
    wreg(ICW_ADDR_LINK_CFG, 8'h20);
    wreg(ICW_ADDR_WDG_LIMIT, 8'h03);
    icw_link_model_i.cycles(2);
    chk("wdg_early", tf, 0);
    icw_link_model_i.cycles(1);
    chk("wdg_fire", {tf, tout, irq, mode}, 8'h1c);
    wreg(ICW_ADDR_LINK_MASK, 8'h00);
    chk("wdg_irq_mask", irq, 0);
    chk("wdg_sio_hold", mode, 0);
    clr_flag();
    @(negedge clk_i);
    chk("wdg_resume", mode, 2);
    // a write to the limit restarts the count, the host's keep-alive
    icw_link_model_i.cycles(2);
    wreg(ICW_ADDR_WDG_LIMIT, 8'h03);
    icw_link_model_i.cycles(2);
    chk("spi_clear", tf, 0);
    icw_link_model_i.cycles(1);
    chk("spi_clear_end", tf, 1);
    clr_flag();
    wreg(ICW_ADDR_CLR_CFG, 8'h01);
    icw_link_model_i.cycles(2);
    @(negedge clk_i);
    pld = 1;
    @(negedge clk_i);
    pld = 0;
    icw_link_model_i.cycles(2);
    chk("load_clear", tf, 0);
    clr_flag();
    icw_link_model_i.set_mode(1, 0);
    icw_link_model_i.cycles(4);
    chk("estcom_idle", tf, 0);
    icw_link_model_i.set_mode(0, 1);
    wreg(ICW_ADDR_WDG_LIMIT, 8'h00);
    icw_link_model_i.cycles(4);
    chk("wdg_off", tf, 0);
  endtask : t_wdg
  initial begin
    clk_i = 1'b0;
    arst_n_i = 1'b0;
    {wr, rd, crc, pld, pwr, fclr} = 6'h00;
    {addr, wd, pa} = 24'h000000;
    fl = 6'h00;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1;
    t_reset();
    t_irq();
    t_cfg();
    t_page();
    t_wdg();
    end_of_test();
  end
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule : icw_regs_tb
`default_nettype wire

// *** src/icw_pkg.sv ***
// icw_pkg: offsets, reset values and field positions of the link config / watchdog registers
// assumes a byte-wide register port driven by the device's spi slave decoder
package icw_pkg;
  localparam logic [7:0] ICW_ADDR_ISDU_MASK = 8'h10;
  localparam logic [7:0] ICW_ADDR_LINK_CFG = 8'h14;
  localparam logic [7:0] ICW_ADDR_WDG_LIMIT = 8'h15;
  localparam logic [7:0] ICW_ADDR_CLR_CFG = 8'h16;
  localparam logic [7:0] ICW_ADDR_LINK_MASK = 8'h0e;
  localparam logic [7:0] ICW_RST_ISDU_MASK = 8'h00;
  localparam logic [7:0] ICW_RST_LINK_CFG = 8'h00;
  localparam logic [7:0] ICW_RST_WDG_LIMIT = 8'h00;
  localparam logic [7:0] ICW_RST_CLR_CFG = 8'h00;
  localparam logic [7:0] ICW_RST_LINK_MASK = 8'h00;
  localparam logic [7:0] ICW_ISDU_MASK_USED = 8'h3f;
  localparam int ICW_CFG_DELAY_LSB = 6;
  localparam int ICW_CFG_DONE_BIT = 5;
  localparam int ICW_CFG_CRC_BIT = 4;
  localparam int ICW_CFG_RATE_LSB = 2;
  localparam int ICW_CFG_PAGE_BIT = 1;
  localparam int ICW_CFG_FORCE_BIT = 0;
  localparam int ICW_LINK_MASK_WDG_BIT = 7;
  localparam int ICW_CLR_MODE_BIT = 0;
  typedef enum logic [1:0] {
    ICW_RATE_COM3,
    ICW_RATE_COM2,
    ICW_RATE_COM1
  } icw_rate_e;
  typedef enum logic [1:0] {
    ICW_MODE_SIO,
    ICW_MODE_ESTCOM,
    ICW_MODE_OPERATE
  } icw_mode_e;
endpackage : icw_pkg

// *** src/icw_regs.sv ***
// icw_regs: isdu interrupt mask, link configuration and cycle watchdog of the data link controller
// assumes a single-cycle byte register port from the spi slave and status inputs on clk_i
// Operation
// - buffer-free flag requests an interrupt only when its mask bit 5 is set
// - check-pdu error flag requests an interrupt only when mask bit 4 is set
// - isdu write-begin flag requests an interrupt only when mask bit 3 is set
// - isdu abort flag requests an interrupt only when mask bit 2 is set
// - isdu idle flag requests an interrupt only when mask bit 1 is set
// - packet flag gated by mask bit 0; all mask bits reset to zero
// - answer delay field 7:6 selects 2, 4, 6 or 8 bit times
// - configuration done at zero keeps the link in sio mode
// - spi crc on when bit 4 set, else follows the crc pin
// - rate field 3:2: 00/11 com3, 01 com2, 10 com1
// - page-one block bit rejects master writes to revision and device ids
// - force bit resets the mode handler and places the link in sio
// - reaching the watchdog count forces sio and sets the timeout flag
// - watchdog does not run in sio or establish-communication mode
// - watchdog count zero disables it; count register resets to zero
// - clear mode 1 clears on process input load, 0 on spi write
// - timeout flag drives the interrupt only with link mask bit 7 set
`timescale 1ns/1ns
`default_nettype none
module icw_regs
  import icw_pkg::*;
#(
  parameter int WDG_WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic [5:0] isdu_flag_register_i,
  input wire logic spi_crc_pin_i,
  input wire logic link_estcom_i,
  input wire logic link_operate_i,
  input wire logic cycle_done_i,
  input wire logic process_input_data_load_i,
  input wire logic page_wr_req_i,
  input wire logic [7:0] page_wr_addr_i,
  input wire logic timeout_flag_clear_i,
  output logic page_wr_accept_o,
  output logic [1:0] answer_delay_sel_o,
  output logic [3:0] answer_delay_bits_o,
  output logic [1:0] link_rate_sel_o,
  output logic [1:0] link_rate_o,
  output logic spi_crc_active_o,
  output logic sio_hold_o,
  output logic mode_handler_reset_o,
  output logic [1:0] link_mode_o,
  output logic cycle_timeout_flag_o,
  output logic cycle_timeout_output_o,
  output logic irq_o
);
  localparam logic [7:0] PAGE_REVISION_ADDR = 8'h04;
  localparam logic [7:0] PAGE_DEVICE_ID1_ADDR = 8'h09;
  localparam logic [7:0] PAGE_DEVICE_ID3_ADDR = 8'h0b;

  initial begin
    if (WDG_WIDTH != 8) $error("watchdog count register is eight bits wide");
  end

  logic [7:0] isdu_mask_q;
  logic [7:0] link_cfg_q;
  logic [7:0] wdg_limit_q;
  logic [7:0] clr_cfg_q;
  logic [7:0] link_mask_q;
  logic [7:0] cycle_cnt_q;
  logic cycle_timeout_flag_q;
  logic crc_pin_meta_q;
  logic crc_pin_q;
  logic [1:0] mode_q;
  logic [7:0] rdata_q;
  logic ack_q;
  logic wr_isdu;
  logic wr_cfg;
  logic wr_wdg;
  logic wr_clr;
  logic wr_lmask;
  logic wdg_active;
  logic wdg_expire;
  logic flag_w1c;
  logic conf_done;
  logic force_sio;

  assign wr_isdu = reg_wr_i && (reg_addr_i == ICW_ADDR_ISDU_MASK);
  assign wr_cfg = reg_wr_i && (reg_addr_i == ICW_ADDR_LINK_CFG);
  assign wr_wdg = reg_wr_i && (reg_addr_i == ICW_ADDR_WDG_LIMIT);
  assign wr_clr = reg_wr_i && (reg_addr_i == ICW_ADDR_CLR_CFG);
  assign wr_lmask = reg_wr_i && (reg_addr_i == ICW_ADDR_LINK_MASK);
  assign conf_done = link_cfg_q[ICW_CFG_DONE_BIT];
  assign force_sio = link_cfg_q[ICW_CFG_FORCE_BIT];

  // unused mask bits 7:6 read as zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      isdu_mask_q <= ICW_RST_ISDU_MASK;
    end else if (wr_isdu) begin
      isdu_mask_q <= reg_wdata_i & ICW_ISDU_MASK_USED;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_cfg_q <= ICW_RST_LINK_CFG;
      clr_cfg_q <= ICW_RST_CLR_CFG;
      link_mask_q <= ICW_RST_LINK_MASK;
    end else begin
      if (wr_cfg) begin
        link_cfg_q <= reg_wdata_i;
      end
      if (wr_clr) begin
        clr_cfg_q <= {7'h00, reg_wdata_i[ICW_CLR_MODE_BIT]};
      end
      if (wr_lmask) begin
        link_mask_q <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdg_limit_q <= ICW_RST_WDG_LIMIT;
    end else if (wr_wdg) begin
      wdg_limit_q <= reg_wdata_i;
    end
  end

  // pin is asynchronous to clk_i
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crc_pin_meta_q <= 1'b0;
      crc_pin_q <= 1'b0;
    end else begin
      crc_pin_meta_q <= spi_crc_pin_i;
      crc_pin_q <= crc_pin_meta_q;
    end
  end

  // link mode tracker: sio until configured and not forced or timed out
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= ICW_MODE_SIO;
    end else if (!conf_done || force_sio || wdg_expire || cycle_timeout_flag_q) begin
      // stays in sio until the host clears the timeout flag, else the link would resume at once
      mode_q <= ICW_MODE_SIO;
    end else if (link_operate_i) begin
      mode_q <= ICW_MODE_OPERATE;
    end else if (link_estcom_i) begin
      mode_q <= ICW_MODE_ESTCOM;
    end else begin
      mode_q <= ICW_MODE_SIO;
    end
  end

  assign wdg_active = (wdg_limit_q != 8'h00) && (mode_q == ICW_MODE_OPERATE);
  assign wdg_expire = wdg_active && cycle_done_i && (cycle_cnt_q + 8'h01 >= wdg_limit_q);

  // counter restarts when the host services it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cycle_cnt_q <= 8'h00;
    end else if (!wdg_active || wdg_expire) begin
      cycle_cnt_q <= 8'h00;
    end else if (clr_cfg_q[ICW_CLR_MODE_BIT] ? process_input_data_load_i : wr_wdg) begin
      cycle_cnt_q <= 8'h00;
    end else if (cycle_done_i) begin
      cycle_cnt_q <= cycle_cnt_q + 8'h01;
    end
  end

  assign flag_w1c = timeout_flag_clear_i;

  // set beats a clear arriving in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cycle_timeout_flag_q <= 1'b0;
    end else if (wdg_expire) begin
      cycle_timeout_flag_q <= 1'b1;
    end else if (flag_w1c) begin
      cycle_timeout_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      ack_q <= reg_rd_i || reg_wr_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          ICW_ADDR_ISDU_MASK: rdata_q <= isdu_mask_q;
          ICW_ADDR_LINK_CFG: rdata_q <= link_cfg_q;
          ICW_ADDR_WDG_LIMIT: rdata_q <= wdg_limit_q;
          ICW_ADDR_CLR_CFG: rdata_q <= clr_cfg_q;
          ICW_ADDR_LINK_MASK: rdata_q <= link_mask_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_ack_o = ack_q;

  // combinational request so masking takes effect at once
  assign irq_o = |(isdu_flag_register_i & isdu_mask_q[5:0])
    || (cycle_timeout_flag_q && link_mask_q[ICW_LINK_MASK_WDG_BIT]);

  assign answer_delay_sel_o = link_cfg_q[ICW_CFG_DELAY_LSB +: 2];
  assign answer_delay_bits_o = {1'b0, link_cfg_q[ICW_CFG_DELAY_LSB +: 2], 1'b0} + 4'h2;
  assign link_rate_sel_o = link_cfg_q[ICW_CFG_RATE_LSB +: 2];

  always_comb begin
    case (link_cfg_q[ICW_CFG_RATE_LSB +: 2])
      2'h1: link_rate_o = ICW_RATE_COM2;
      2'h2: link_rate_o = ICW_RATE_COM1;
      default: link_rate_o = ICW_RATE_COM3;
    endcase
  end

  assign spi_crc_active_o = link_cfg_q[ICW_CFG_CRC_BIT] || crc_pin_q;
  assign page_wr_accept_o = page_wr_req_i && !(link_cfg_q[ICW_CFG_PAGE_BIT]
    && (page_wr_addr_i == PAGE_REVISION_ADDR
    || (page_wr_addr_i >= PAGE_DEVICE_ID1_ADDR && page_wr_addr_i <= PAGE_DEVICE_ID3_ADDR)));
  assign sio_hold_o = !conf_done || force_sio;
  assign mode_handler_reset_o = force_sio;
  assign link_mode_o = mode_q;
  assign cycle_timeout_flag_o = cycle_timeout_flag_q;
  assign cycle_timeout_output_o = cycle_timeout_flag_q;

  a_mask_gates_irq: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (isdu_flag_register_i[5] && isdu_mask_q[5]) |-> irq_o)
    else $error("enabled buffer-free flag did not raise irq");
  a_pdu_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (isdu_flag_register_i[4] && isdu_mask_q[4]) |-> irq_o)
    else $error("enabled check-pdu flag did not raise irq");
  a_begin_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (isdu_flag_register_i[3] && isdu_mask_q[3]) |-> irq_o)
    else $error("enabled write-begin flag did not raise irq");
  a_abort_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (isdu_flag_register_i[2] && isdu_mask_q[2]) |-> irq_o)
    else $error("enabled abort flag did not raise irq");
  a_idle_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (isdu_flag_register_i[1] && isdu_mask_q[1]) |-> irq_o)
    else $error("enabled idle flag did not raise irq");
  a_irq_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!(|(isdu_flag_register_i & isdu_mask_q[5:0])) && !(cycle_timeout_flag_q && link_mask_q[7])) |-> !irq_o)
    else $error("irq asserted with no enabled flag");
  a_sio_unconf: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !conf_done |=> link_mode_o == ICW_MODE_SIO)
    else $error("link left sio before configuration done");
  a_force_sio: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    force_sio |-> (mode_handler_reset_o && sio_hold_o) ##1 (link_mode_o == ICW_MODE_SIO))
    else $error("force bit did not hold link in sio");
  a_wdg_expire: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wdg_expire |=> cycle_timeout_flag_o && (link_mode_o == ICW_MODE_SIO))
    else $error("watchdog expiry did not set flag and sio");
  a_wdg_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (link_mode_o != ICW_MODE_OPERATE) |=> (cycle_cnt_q == 8'h00))
    else $error("watchdog counted outside operate mode");
  a_wdg_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wdg_limit_q == 8'h00) |-> !wdg_expire)
    else $error("disabled watchdog expired");
  a_crc_pin: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!link_cfg_q[4] && $stable(link_cfg_q[4]) && $past(spi_crc_pin_i, 2) && $past(spi_crc_pin_i)) |-> spi_crc_active_o)
    else $error("crc pin not honoured");
  a_delay_map: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (answer_delay_sel_o == 2'h3) |-> (answer_delay_bits_o == 4'h8))
    else $error("answer delay code 11 not 8 bit times");
  a_packet_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (isdu_flag_register_i[0] && isdu_mask_q[0]) |-> irq_o)
    else $error("enabled packet flag did not raise irq");
  a_wdg_irq_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (cycle_timeout_flag_q && link_mask_q[ICW_LINK_MASK_WDG_BIT]) |-> irq_o)
    else $error("enabled timeout flag did not raise irq");
  a_page_block: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (page_wr_req_i && link_cfg_q[ICW_CFG_PAGE_BIT]
    && (page_wr_addr_i == PAGE_REVISION_ADDR || page_wr_addr_i == PAGE_DEVICE_ID3_ADDR)) |-> !page_wr_accept_o)
    else $error("blocked page write accepted");
  a_page_open: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (page_wr_req_i && !link_cfg_q[ICW_CFG_PAGE_BIT]) |-> page_wr_accept_o)
    else $error("page write refused with block bit clear");
  a_rate_map: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (link_rate_sel_o == 2'h2) |-> (link_rate_o == ICW_RATE_COM1))
    else $error("rate code 10 not com1");
  a_crc_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    link_cfg_q[ICW_CFG_CRC_BIT] |-> spi_crc_active_o)
    else $error("crc bit set but crc inactive");
  a_spi_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!clr_cfg_q[ICW_CLR_MODE_BIT] && wr_wdg) |=> (cycle_cnt_q == 8'h00))
    else $error("spi write did not clear the watchdog count");
  a_load_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (clr_cfg_q[ICW_CLR_MODE_BIT] && process_input_data_load_i) |=> (cycle_cnt_q == 8'h00))
    else $error("data load did not clear the watchdog count");
  a_timeout_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cycle_timeout_flag_q |=> (link_mode_o == ICW_MODE_SIO))
    else $error("link left sio with timeout flag set");
endmodule : icw_regs
`default_nettype wire
